/* verilog/radio_clock_status_display.sv */
// status, lock indicator, display blanking and offset logic of the radio clock
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module radio_clock_status_display #(
    parameter int unsigned HALF_SEC = radio_clock_pkg::HALF_SEC_CYCLES  // cycles per half second
) (
    input  wire logic                  clk,          // 200 MHz
    input  wire logic                  resetn,       // async reset, active low
    input  wire logic                  lockPin,      // carrier phase lock from front end
    input  wire logic                  frameStrobe,  // one decoded minute frame ready
    input  wire radio_clock_pkg::tod_s frameTime,    // decoded day, hour, minute
    input  wire logic                  hsel,         // ahb select
    input  wire logic [31:0]           haddr,        // ahb address
    input  wire logic [1:0]            htrans,       // ahb transfer type
    input  wire logic                  hwrite,       // ahb write
    input  wire logic [2:0]            hsize,        // ahb size
    input  wire logic [31:0]           hwdata,       // ahb write data
    input  wire logic                  hready,       // ahb bus ready
    output logic [31:0]                hrdata,       // ahb read data
    output logic                       hreadyout,    // ahb slave ready
    output logic                       hresp,        // ahb response, always okay
    output logic                       carrier_lock_indicator, // lock led
    output logic                       colonOn,      // colon segments lit
    output logic                       digitsOn,     // digit segments lit
    output radio_clock_pkg::tod_s      dispTime,     // corrected time to display
    output radio_clock_pkg::tod_s      outTime,      // corrected time to outputs
    output logic                       irq           // level interrupt
);
    import radio_clock_pkg::*;

    // reset release through two flops
    logic rstMeta_q, rstSync_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end
    wire logic rstn = rstSync_q;

    // lock pin synchroniser
    logic lockMeta_q, lockSync_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lockMeta_q <= 1'b0;
            lockSync_q <= 1'b0;
        end else begin
            lockMeta_q <= lockPin;
            lockSync_q <= lockMeta_q;
        end
    end

    // advances a time value by one minute, day wraps after the last day of year
    function automatic tod_s nextMinute(input tod_s t);
        tod_s r;
        r = t;
        r.second = 6'h00;
        if (t.minute == 6'h3b) begin
            r.minute = 6'h00;
            if (t.hour == 5'h17) begin
                r.hour = 5'h00;
                r.day  = (t.day == DAYS_PER_YEAR) ? 9'h001 : 9'(t.day + 9'h001);
            end else begin
                r.hour = 5'(t.hour + 5'h01);
            end
        end else begin
            r.minute = 6'(t.minute + 6'h01);
        end
        return r;
    endfunction : nextMinute

    // state registers
    logic [31:0]           halfCnt_q, halfCnt_d;
    logic                  halfPh_q, halfPh_d;
    logic [4:0]            lossSec_q, lossSec_d;
    logic                  led_q, led_d;
    colon_e                colSt_q, colSt_d;
    tod_s                  tod_q, tod_d;
    tod_s                  prevFrame_q, prevFrame_d, prevNext;
    logic                  prevValid_q, prevValid_d;
    logic                  synced_q, synced_d;
    logic [16:0]           unlockAcc_q, unlockAcc_d;
    logic [3:0]            offset_q, offset_d;
    logic                  fmt12_q, fmt12_d;
    logic [NUM_EVENTS-1:0] intStat_q, intStat_d;
    logic [NUM_EVENTS-1:0] intMask_q, intMask_d;
    logic                  wrPend_q, wrPend_d;
    logic [7:0]            wrAddr_q, wrAddr_d;
    logic [31:0]           rdata_q, rdata_d;
    logic                  colon_q, colon_d;
    logic                  digits_q, digits_d;
    tod_s                  disp_q, disp_d;
    logic                  irq_q, irq_d;

    logic                  halfTick, secTick, match, colonFl, fullFl;
    logic [NUM_EVENTS-1:0] events;
    logic [4:0]            hrLocal;
    logic [8:0]            dayLocal;
    logic [8:0]            dayDec;
    logic [4:0]            hrWrap;

    // half-second time base; a full second ends on every second half tick
    always_comb begin
        halfTick  = (halfCnt_q == HALF_SEC - 1);
        secTick   = halfTick && halfPh_q;
        halfCnt_d = halfTick ? 32'h0000_0000 : halfCnt_q + 32'h0000_0001;
        halfPh_d  = halfTick ? ~halfPh_q : halfPh_q;
    end

    // lock indicator with loss hold-off counted in seconds
    always_comb begin
        lossSec_d = lossSec_q;
        led_d     = led_q;
        if (lockSync_q) begin
            lossSec_d = 5'h00;
            led_d     = 1'b1;
        end else if (secTick && led_q) begin
            lossSec_d = 5'(lossSec_q + 5'h01);
            if (lossSec_q == LOCK_LOSS_SEC) begin
                led_d = 1'b0;
            end
        end
    end

    // frame pairing: a frame must follow the stored one by exactly one minute
    always_comb begin
        prevNext    = nextMinute(prevFrame_q);
        match       = frameStrobe && lockSync_q && prevValid_q
                      && (frameTime[25:6] == prevNext[25:6]);
        prevFrame_d = prevFrame_q;
        prevValid_d = prevValid_q;
        if (frameStrobe) begin
            prevFrame_d = frameTime;
            prevValid_d = lockSync_q;
        end
        if (!lockSync_q) begin
            prevValid_d = 1'b0;
        end
    end

    // running clock, display validity and unlocked-time accumulator
    always_comb begin
        tod_d       = tod_q;
        synced_d    = synced_q;
        unlockAcc_d = unlockAcc_q;
        if (match) begin
            tod_d        = frameTime;
            tod_d.second = FRAME_INFO_SEC;                // info ends at second 35
            synced_d     = 1'b1;
            unlockAcc_d  = 17'h00000;
        end else if (secTick) begin
            if (tod_q.second == 6'h3b) begin
                tod_d = nextMinute(tod_q);
            end else begin
                tod_d.second = 6'(tod_q.second + 6'h01);
            end
            if (synced_q && !lockSync_q && unlockAcc_q != FULL_FLASH_SEC) begin
                unlockAcc_d = 17'(unlockAcc_q + 17'h00001);
            end
        end
        colonFl = synced_q && (unlockAcc_q >= COLON_FLASH_SEC);
        fullFl  = synced_q && (unlockAcc_q >= FULL_FLASH_SEC);
    end

    // power-up colon sequence: on for a half second, off for a half second, then steady
    always_comb begin
        colSt_d = colSt_q;
        case (colSt_q)
            COL_ON: begin
                if (halfTick) colSt_d = COL_OFF;
            end
            COL_OFF: begin
                if (halfTick) colSt_d = COL_RUN;
            end
            COL_RUN: begin
                colSt_d = COL_RUN;
            end
            default: begin
                colSt_d = COL_ON;
            end
        endcase
    end

    // segment enables; flashing uses the half-second phase
    always_comb begin
        colon_d  = (colSt_q != COL_OFF);
        digits_d = synced_q;
        if (colonFl || fullFl) begin
            colon_d = halfPh_q;
        end
        if (fullFl) begin
            digits_d = halfPh_q;
        end
    end

    // offset subtraction with day borrow, then 12-hour mapping
    always_comb begin
        dayDec   = (tod_q.day == 9'h001) ? DAYS_PER_YEAR : 9'(tod_q.day - 9'h001);
        hrWrap   = 5'(tod_q.hour + 5'h18 - {1'b0, offset_q});
        hrLocal  = 5'(tod_q.hour - {1'b0, offset_q});
        dayLocal = tod_q.day;
        if (tod_q.hour < {1'b0, offset_q}) begin
            hrLocal  = hrWrap;
            dayLocal = dayDec;
        end
        if (fmt12_q) begin
            if (hrLocal == 5'h00) begin
                hrLocal = 5'h0c;
            end else if (hrLocal > 5'h0c) begin
                hrLocal = 5'(hrLocal - 5'h0c);
            end
        end
        disp_d        = tod_q;
        disp_d.hour   = hrLocal;
        disp_d.day    = dayLocal;
    end

    // interrupt events, set wins over a write-one clear in the same cycle
    always_comb begin
        events              = '0;
        events[EV_LOCK_ON]  = led_d && !led_q;
        events[EV_LOCK_OFF] = !led_d && led_q;
        events[EV_SYNCED]   = match && !synced_q;
        events[EV_COLON_FL] = synced_q && (unlockAcc_d == COLON_FLASH_SEC)
                              && (unlockAcc_q != COLON_FLASH_SEC);
        events[EV_FULL_FL]  = synced_q && (unlockAcc_d == FULL_FLASH_SEC)
                              && (unlockAcc_q != FULL_FLASH_SEC);
    end

    // ahb slave: zero wait states, write applied in the data phase
    always_comb begin
        wrPend_d  = 1'b0;
        wrAddr_d  = wrAddr_q;
        rdata_d   = 32'h0000_0000;
        offset_d  = offset_q;
        fmt12_d   = fmt12_q;
        intMask_d = intMask_q;
        intStat_d = intStat_q;
        if (wrPend_q) begin
            if (wrAddr_q == OFS_CTRL) begin
                offset_d = (hwdata[CTRL_OFFSET_LSB +: 4] > MAX_OFFSET)
                           ? MAX_OFFSET : hwdata[CTRL_OFFSET_LSB +: 4];
                fmt12_d  = hwdata[CTRL_FMT12_BIT];
            end else if (wrAddr_q == OFS_INT_STAT) begin
                intStat_d = intStat_q & ~hwdata[NUM_EVENTS-1:0];
            end else if (wrAddr_q == OFS_INT_MASK) begin
                intMask_d = hwdata[NUM_EVENTS-1:0];
            end
        end
        intStat_d = intStat_d | events;
        if (hsel && htrans[1] && hready) begin
            wrPend_d = hwrite;
            wrAddr_d = haddr[7:0];
            if (!hwrite) begin
                if (haddr[7:0] == OFS_CTRL) begin
                    rdata_d = {27'h0, fmt12_q, offset_q};
                end else if (haddr[7:0] == OFS_STATUS) begin
                    rdata_d = {25'h0, colSt_q == COL_RUN, fullFl, colonFl, prevValid_q,
                               synced_q, led_q, lockSync_q};
                end else if (haddr[7:0] == OFS_TIME) begin
                    rdata_d = {6'h0, disp_q};
                end else if (haddr[7:0] == OFS_INT_STAT) begin
                    rdata_d = {27'h0, intStat_q};
                end else if (haddr[7:0] == OFS_INT_MASK) begin
                    rdata_d = {27'h0, intMask_q};
                end else begin
                    rdata_d = 32'h0000_0000;              // unmapped reads zero
                end
            end
        end
        irq_d = |(intStat_d & intMask_d);
    end

    // all state registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            halfCnt_q   <= 32'h0000_0000;
            halfPh_q    <= 1'b0;
            lossSec_q   <= 5'h00;
            led_q       <= 1'b0;
            colSt_q     <= COL_ON;
            tod_q       <= TOD_RESET;
            prevFrame_q <= TOD_RESET;
            prevValid_q <= 1'b0;
            synced_q    <= 1'b0;
            unlockAcc_q <= 17'h00000;
            offset_q    <= OFFSET_RESET;
            fmt12_q     <= FMT12_RESET;
            intStat_q   <= INT_RESET;
            intMask_q   <= INT_RESET;
            wrPend_q    <= 1'b0;
            wrAddr_q    <= 8'h00;
            rdata_q     <= 32'h0000_0000;
            colon_q     <= 1'b1;
            digits_q    <= 1'b0;
            disp_q      <= TOD_RESET;
            irq_q       <= 1'b0;
        end else begin
            halfCnt_q   <= halfCnt_d;
            halfPh_q    <= halfPh_d;
            lossSec_q   <= lossSec_d;
            led_q       <= led_d;
            colSt_q     <= colSt_d;
            tod_q       <= tod_d;
            prevFrame_q <= prevFrame_d;
            prevValid_q <= prevValid_d;
            synced_q    <= synced_d;
            unlockAcc_q <= unlockAcc_d;
            offset_q    <= offset_d;
            fmt12_q     <= fmt12_d;
            intStat_q   <= intStat_d;
            intMask_q   <= intMask_d;
            wrPend_q    <= wrPend_d;
            wrAddr_q    <= wrAddr_d;
            rdata_q     <= rdata_d;
            colon_q     <= colon_d;
            digits_q    <= digits_d;
            disp_q      <= disp_d;
            irq_q       <= irq_d;
        end
    end

    // outputs straight from flops except hresp, tied to okay; the electrical output shares the display copy
    assign hrdata                 = rdata_q;
    assign hreadyout              = rstSync_q;
    assign hresp                  = 1'b0;
    assign carrier_lock_indicator = led_q;
    assign colonOn                = colon_q;
    assign digitsOn               = digits_q;
    assign dispTime               = disp_q;
    assign outTime                = disp_q;
    assign irq                    = irq_q;

endmodule : radio_clock_status_display
`default_nettype wire

/* verilog/radio_clock_pkg.sv */
// constants, types and register map of the radio clock status and display block
package radio_clock_pkg;

    // clock and time figures
    localparam int unsigned CLK_HZ          = 200_000_000;
    localparam int unsigned HALF_SEC_CYCLES = CLK_HZ / 2;
    localparam int unsigned LOCK_LOSS_S     = 16;
    localparam int unsigned COLON_FLASH_MIN = 92;
    localparam int unsigned FULL_FLASH_H    = 22;
    localparam int unsigned FRAME_INFO_S    = 35;
    localparam logic [16:0] COLON_FLASH_SEC = 17'(COLON_FLASH_MIN * 60);
    localparam logic [16:0] FULL_FLASH_SEC  = 17'(FULL_FLASH_H * 3600);
    localparam logic [4:0]  LOCK_LOSS_SEC   = 5'(LOCK_LOSS_S);
    localparam logic [5:0]  FRAME_INFO_SEC  = 6'(FRAME_INFO_S);
    localparam logic [8:0]  DAYS_PER_YEAR   = 9'h16e;
    localparam logic [3:0]  MAX_OFFSET      = 4'hb;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_TIME     = 8'h08;
    localparam logic [7:0] OFS_INT_STAT = 8'h0c;
    localparam logic [7:0] OFS_INT_MASK = 8'h10;

    // control fields and reset values
    localparam int unsigned CTRL_OFFSET_LSB = 0;
    localparam int unsigned CTRL_FMT12_BIT  = 4;
    localparam logic [3:0]  OFFSET_RESET    = 4'h0;
    localparam logic        FMT12_RESET     = 1'b0;

    // interrupt event bits
    localparam int unsigned NUM_EVENTS   = 5;
    localparam int unsigned EV_LOCK_ON   = 0;
    localparam int unsigned EV_LOCK_OFF  = 1;
    localparam int unsigned EV_SYNCED    = 2;
    localparam int unsigned EV_COLON_FL  = 3;
    localparam int unsigned EV_FULL_FL   = 4;
    localparam logic [NUM_EVENTS-1:0] INT_RESET = 5'h00;

    // time of year as carried by frames and outputs
    typedef struct packed {
        logic [8:0] day;
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
    } tod_s;

    localparam tod_s TOD_RESET = '{day: 9'h001, hour: 5'h00, minute: 6'h00, second: 6'h00};

    // power-up colon sequence, one-hot
    typedef enum logic [2:0] {
        COL_ON  = 3'b001,
        COL_OFF = 3'b010,
        COL_RUN = 3'b100
    } colon_e;

endpackage : radio_clock_pkg

/* testbench/radio_clock_chk.sv */
// assertion checker for the radio clock status and display block
`timescale 1ns/1ps
`default_nettype none
module radio_clock_chk #(
    parameter int unsigned HALF_SEC = 4 // cycles per half second
) (
    input wire logic                  clk,                    // block clock
    input wire logic                  resetn,                 // async reset, active low
    input wire logic                  lockPin,                // carrier lock input
    input wire logic                  frameStrobe,            // frame pulse
    input wire logic                  hreadyout,              // high once out of reset
    input wire logic                  carrier_lock_indicator, // lock led
    input wire logic                  colonOn,                // colon segments
    input wire logic                  digitsOn,               // digit segments
    input wire radio_clock_pkg::tod_s dispTime,               // displayed time
    input wire radio_clock_pkg::tod_s outTime                 // output time
);
    import radio_clock_pkg::*;
    logic [31:0] lowCnt_q;
    logic [31:0] lowCnt_d;

    // cycles the lock pin has been low; the led hold-off is judged against it
    always_comb lowCnt_d = lockPin ? 32'h0 : lowCnt_q + 32'h1;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            lowCnt_q <= 32'h0;
        else
            lowCnt_q <= lowCnt_d;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_lock_follow: assert property ((lockPin && hreadyout) [*3] |=> carrier_lock_indicator)
        else $error("lock led late");
    a_lock_hold: assert property ($fell(carrier_lock_indicator) |-> lowCnt_q >= 32 * HALF_SEC)
        else $error("lock led dropped early");
    a_lock_drop: assert property (lowCnt_q == 36 * HALF_SEC |-> !carrier_lock_indicator)
        else $error("lock led still lit");
    a_sync_cause: assert property ($rose(digitsOn) |-> $past(frameStrobe, 2) && carrier_lock_indicator)
        else $error("display lit without frame and lock");
    a_out_same: assert property (outTime == dispTime)
        else $error("output time differs from display");
    a_tod_range: assert property (dispTime.hour < 5'd24 && dispTime.minute < 6'd60)
        else $error("displayed time out of range");
    a_digit_blank: assert property ($rose(hreadyout) |-> !digitsOn ##1 !digitsOn)
        else $error("digits lit at power-up");
    a_colon_boot: assert property ($rose(hreadyout) |-> colonOn ##1 colonOn ##1 colonOn)
        else $error("colons not lit at power-up");

    c_sync: cover property ($rose(digitsOn));
    c_lock_on: cover property ($rose(carrier_lock_indicator));
    c_lock_off: cover property ($fell(carrier_lock_indicator));
endmodule : radio_clock_chk

bind radio_clock_status_display radio_clock_chk #(.HALF_SEC(HALF_SEC)) chk_u (
    .clk(clk), .resetn(resetn), .lockPin(lockPin), .frameStrobe(frameStrobe),
    .hreadyout(hreadyout), .carrier_lock_indicator(carrier_lock_indicator),
    .colonOn(colonOn), .digitsOn(digitsOn), .dispTime(dispTime), .outTime(outTime));
`default_nettype wire

/* testbench/front_end_model.sv */
// receiver front end model: carrier lock level and decoded minute frames
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
    input  wire logic             clk,         // block clock
    output logic                  lockPin,     // carrier lock, high when locked
    output logic                  frameStrobe, // one-cycle frame pulse
    output radio_clock_pkg::tod_s frameTime    // frame, toggling garbage when idle
);
    import radio_clock_pkg::*;
    tod_s held;
    tod_s idle;

    // idle bus flips every cycle so a stale frame never looks valid
    initial begin
        lockPin = 1'b0;
        frameStrobe = 1'b0;
        idle = '0;
    end
    always @(posedge clk) idle <= ~idle;
    assign frameTime = frameStrobe ? held : idle;

    // lock level as the phase lock loop reports it
    task automatic set_lock(input logic on);
        lockPin <= on;
    endtask : set_lock

    // one decoded minute frame, entered just after a clock edge
    task automatic send_frame(input tod_s t);
        held <= t;
        frameStrobe <= 1'b1;
        @(posedge clk);
        frameStrobe <= 1'b0;
    endtask : send_frame
endmodule : front_end_model
`default_nettype wire

/* testbench/tb.sv */
// self-checking testbench of the radio clock status and display block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import radio_clock_pkg::*;
    localparam int unsigned HS  = 4;  // short half second keeps the run brief
    localparam int          SEC = 2 * HS;
    logic        clk, resetn, hsel, hwrite, hreadyout, hresp;
    logic        lockLed, colonOn, digitsOn, irq, lockPin, frameStrobe;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    tod_s        frameTime, dispTime, outTime;
    int          n_mismatch, check_count;

    radio_clock_status_display #(.HALF_SEC(HS)) dut_u (
        .clk(clk), .resetn(resetn), .lockPin(lockPin), .frameStrobe(frameStrobe),
        .frameTime(frameTime), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .carrier_lock_indicator(lockLed), .colonOn(colonOn), .digitsOn(digitsOn),
        .dispTime(dispTime), .outTime(outTime), .irq(irq));
    front_end_model fe_u (.clk(clk), .lockPin(lockPin), .frameStrobe(frameStrobe),
        .frameTime(frameTime));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // one single word transfer; read data taken at the edge ending the data phase
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb

    function automatic tod_s mk(input int h, input int m);
        return '{day: 9'd100, hour: 5'(h), minute: 6'(m), second: 6'h00};
    endfunction : mk

    // colon lit cycles over two seconds: 16 steady, 8 flashing
    task automatic colons(input int exp);
        int n;
        n = 0;
        repeat (2 * SEC) begin
            @(posedge clk);
            n += int'(colonOn);
        end
        check(32'(n), 32'(exp));
    endtask : colons

    task automatic t_boot;
        while (hreadyout !== 1'b1) @(posedge clk);
        tick(2);
        check(32'(colonOn), 32'h1);
        check(32'(digitsOn), 32'h0);
        tick(4);
        check(32'(colonOn), 32'h0);
        tick(6);
        check(32'(colonOn), 32'h1);
        fe_u.send_frame(mk(18, 30));
        tick(10);
        fe_u.send_frame(mk(18, 31));
        tick(10);
        check(32'(digitsOn), 32'h0);
        $display("boot and unlocked frames done");
    endtask : t_boot

    task automatic t_sync;
        fe_u.set_lock(1'b1);
        tick(5);
        check(32'(lockLed), 32'h1);
        fe_u.send_frame(mk(18, 30));
        tick(20);
        fe_u.send_frame(mk(18, 31));
        tick(4);
        check(32'(digitsOn), 32'h1);
        check(32'(dispTime[25:6]), 32'({9'd100, 5'd18, 6'd31}));
        check(32'(dispTime.second >= 6'd35), 32'h1);
        ahb(1'b0, OFS_INT_STAT, 32'h0, rd);
        check(32'(rd[EV_SYNCED]), 32'h1);
        ahb(1'b0, 8'h40, 32'h0, rd);
        check(rd, 32'h0);
        check(32'(hresp), 32'h0);
        $display("sync done");
    endtask : t_sync

    task automatic t_irq;
        logic a;
        ahb(1'b1, OFS_INT_MASK, 32'h0, rd);
        tick(2);
        a = irq;
        ahb(1'b1, OFS_INT_MASK, 32'h1f, rd);
        tick(2);
        check(32'({a, irq}), 32'h1);
        ahb(1'b1, OFS_INT_STAT, 32'h1f, rd);
        tick(2);
        check(32'(irq), 32'h0);
        ahb(1'b0, OFS_INT_STAT, 32'h0, rd);
        check(rd, 32'h0);
        $display("interrupt done");
    endtask : t_irq

    // utc hour 18 under offsets and formats; 0x0f clamps to eleven
    task automatic t_offset;
        logic [7:0] cv [6] = '{8'h00, 8'h05, 8'h15, 8'h10, 8'h16, 8'h0f};
        int         eh [6] = '{18, 13, 1, 6, 12, 7};
        for (int i = 0; i < 6; i++) begin
            ahb(1'b1, OFS_CTRL, 32'(cv[i]), rd);
            tick(3);
            check(32'(dispTime.hour), 32'(eh[i]));
            check(32'(outTime.hour), 32'(eh[i]));
        end
        ahb(1'b0, OFS_CTRL, 32'h0, rd);
        check(rd, 32'h0b);
        ahb(1'b1, OFS_CTRL, 32'h0, rd);
        $display("offset done");
    endtask : t_offset

    task automatic t_loss;
        fe_u.set_lock(1'b0);
        tick(15 * SEC);
        check(32'(lockLed), 32'h1);
        tick(4 * SEC);
        check(32'(lockLed), 32'h0);
        ahb(1'b0, OFS_INT_STAT, 32'h0, rd);
        check(32'(rd[EV_LOCK_OFF]), 32'h1);
        tick(5480 * SEC);
        colons(16);
        tick(24 * SEC);
        colons(8);
        check(32'(digitsOn), 32'h1);
        fe_u.set_lock(1'b1);
        tick(5);
        fe_u.send_frame(mk(20, 0));
        tick(20);
        fe_u.send_frame(mk(20, 1));
        tick(4);
        colons(16);
        fe_u.set_lock(1'b0);
        tick(30 * SEC);
        colons(16);
        $display("loss and flash done");
    endtask : t_loss

    // watchdog well beyond the expected run
    initial begin
        #300000;
        n_mismatch++;
        summarize;
    end

    initial begin
        resetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        n_mismatch = 0;
        check_count = 0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        t_boot;
        t_sync;
        t_irq;
        t_offset;
        t_loss;
        summarize;
    end
endmodule : tb
`default_nettype wire
